// file: pkg/jfcc_pkg.sv
package jfcc_pkg;

  // Synchroniser depth for the power-on reset release in the mclk domain
  localparam int unsigned JFCC_SYNC_STAGES = 2;

  // Reset value of a synchronised pin level (test mode select idles high)
  localparam logic        JFCC_PIN_IDLE    = 1'b1;

  // Rising edges of test mode select that end the check window
  localparam logic [1:0]  JFCC_RISE_LIMIT  = 2'h2;

  typedef enum logic [1:0] {
    JFCC_IDLE,
    JFCC_ACTIVE,
    JFCC_DONE
  } jfcc_mode_e;

  // Reset synchroniser state
  typedef struct packed {
    logic [JFCC_SYNC_STAGES-1:0] stage;
  } jfcc_sync_s;

  // Controller state
  typedef struct packed {
    jfcc_mode_e mode;
    logic [1:0] rises;
    logic       tms_prev;
    logic       first;
    logic       path_en;
  } jfcc_ctl_s;

  // Pin samples for test mode select and test data in
  typedef struct packed {
    logic tms_meta;
    logic tms_sync;
    logic tdi_meta;
    logic tdi_sync;
  } jfcc_pin_s;

endpackage

// file: logic/jfcc_sync2.sv
`timescale 1ns/10ps
module jfcc_sync2
  import jfcc_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Level in and out
  input  wire logic d,
  output logic      q
);

  typedef struct packed {
    logic meta;
    logic sync;
  } jfcc_s2_s;

  jfcc_s2_s st_reg;
  jfcc_s2_s st_next;

  always_comb begin
    st_next      = st_reg;
    st_next.meta = d;
    st_next.sync = st_reg.meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= {RESET_VAL, RESET_VAL};
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.sync;

endmodule // jfcc_sync2

// file: logic/jfcc_fuse_check.sv
// Operation
// R1: Every power-on reset re-arms the fuse check so it can run on the first port access.
// R2: The mode turns on at the first falling edge of test mode select, or at power-up if it is low.
// R3: The mode turns off at the second rising edge of test mode select after power-up.
// R4: Once off, the mode stays off and ignores test mode select until the next power-on reset.
// R5: The fuse check current path is enabled only while the mode is on and test mode select is low.
// R6: The probe or board should hold test mode select high by default to avoid accidental activation.
// R7: An idle, active, done state machine, cleared only by power-on reset, tracks the edges.
`timescale 1ns/10ps
module jfcc_fuse_check
  import jfcc_pkg::*;
(
  // Clock and power-on reset
  input  wire logic mclk,
  input  wire logic arst_n,
  // Test port pins
  input  wire logic tms_pin,
  input  wire logic test_data_in_test_clock_pin,
  // Fuse check
  output logic      fuse_check_current,
  output logic      fuse_check_active,
  output logic      fuse_check_done,
  output logic      fuse_intact
);

  jfcc_sync_s rst_reg;
  jfcc_sync_s rst_next;
  logic       rst_n;
  logic       tms_s;
  logic       tdi_s;
  jfcc_ctl_s  ctl_reg;
  jfcc_ctl_s  ctl_next;
  logic       fell;
  logic       rose;

  // Reset release through two flops
  always_comb begin
    rst_next       = rst_reg;
    rst_next.stage = {rst_reg.stage[JFCC_SYNC_STAGES-2:0], 1'b1};
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_reg <= '0;
    end else begin
      rst_reg <= rst_next;
    end
  end

  assign rst_n = rst_reg.stage[JFCC_SYNC_STAGES-1];

  jfcc_sync2 #(
    .RESET_VAL (JFCC_PIN_IDLE)
  ) u_tms_sync (
    .clk   (mclk),
    // Pin sampling runs while reset release settles, so the first state sample sees the pin
    .rst_n (arst_n),
    .d     (tms_pin),
    .q     (tms_s)
  );

  jfcc_sync2 #(
    .RESET_VAL (1'b0)
  ) u_tdi_sync (
    .clk   (mclk),
    .rst_n (arst_n),
    .d     (test_data_in_test_clock_pin),
    .q     (tdi_s)
  );

  assign fell = ctl_reg.tms_prev & ~tms_s;
  assign rose = ~ctl_reg.tms_prev & tms_s;

  always_comb begin
    ctl_next          = ctl_reg;
    ctl_next.tms_prev = tms_s;
    ctl_next.first    = 1'b0;
    case (ctl_reg.mode)
      JFCC_IDLE: begin
        // First sample after release sees a level held low through power-up
        if ((ctl_reg.first && !tms_s) || fell) begin // R2
          ctl_next.mode = JFCC_ACTIVE;
        end
        if (rose) begin
          ctl_next.rises = ctl_reg.rises + 2'h1;
        end
      end
      JFCC_ACTIVE: begin
        if (rose) begin
          ctl_next.rises = ctl_reg.rises + 2'h1;
          if (ctl_reg.rises + 2'h1 >= JFCC_RISE_LIMIT) begin // R3
            ctl_next.mode = JFCC_DONE;
          end
        end
      end
      JFCC_DONE: begin
        ctl_next.rises = ctl_reg.rises; // R4
      end
      default: begin
        ctl_next.mode = JFCC_DONE;
      end
    endcase
    ctl_next.path_en = (ctl_next.mode == JFCC_ACTIVE) && !tms_s; // R5
  end

  // Only power-on reset clears the state
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_reg.mode     <= JFCC_IDLE; // R1 R7
      ctl_reg.rises    <= 2'h0;
      ctl_reg.tms_prev <= JFCC_PIN_IDLE;
      ctl_reg.first    <= 1'b1;
      ctl_reg.path_en  <= 1'b0;
    end else begin
      ctl_reg <= ctl_next; // R7
    end
  end

  // Intact fuse pulls data pin low while the path is on
  logic intact_reg;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      intact_reg <= 1'b0;
    end else if (ctl_reg.path_en) begin
      intact_reg <= ~tdi_s;
    end
  end

  assign fuse_check_current = ctl_reg.path_en;
  assign fuse_check_active  = (ctl_reg.mode == JFCC_ACTIVE);
  assign fuse_check_done    = (ctl_reg.mode == JFCC_DONE);
  assign fuse_intact        = intact_reg;

endmodule // jfcc_fuse_check

// file: bench/jfcc_probe.sv
`timescale 1ns/10ps
module jfcc_probe (
  // Clock and fuse model
  input  wire logic mclk,
  input  wire logic fuse_ok,
  input  wire logic fuse_path,
  // Test port pins
  output logic      tms_pin,
  output logic      tdi_pin
);
  initial tms_pin = 1'h1;
  // Intact fuse sinks the pin while the path is on
  assign tdi_pin = fuse_path ? !fuse_ok : 1'h1;
  task automatic drive(input logic v);
    @(negedge mclk);
    tms_pin = v;
  endtask
endmodule // jfcc_probe

// file: bench/jfcc_fuse_check_asserts.sv
`timescale 1ns/10ps
module jfcc_fuse_check_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Pin and outputs
  input wire logic tms_pin,
  input wire logic fuse_check_current,
  input wire logic fuse_check_active,
  input wire logic fuse_check_done
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  a_path_needs_mode: assert property (fuse_check_current |-> fuse_check_active)
    else $error("path on outside mode");
  a_high_no_path: assert property (tms_pin [*6] |-> !fuse_check_current)
    else $error("path on with tms high");
  a_low_gives_path: assert property ((fuse_check_active && !tms_pin) [*6] |-> fuse_check_current)
    else $error("path off in mode");
  a_low_enters_mode: assert property ((!fuse_check_done && !tms_pin) [*8] |-> fuse_check_active)
    else $error("mode not entered");
  a_exit_to_done: assert property ($fell(fuse_check_active) |-> fuse_check_done)
    else $error("exit not to done");
  a_done_sticky: assert property (fuse_check_done |=> fuse_check_done && !fuse_check_active)
    else $error("done left");
  a_done_from_mode: assert property ($rose(fuse_check_done) |-> $past(fuse_check_active))
    else $error("done without mode");
  a_por_rearms: assert property ($rose(arst_n) |-> !fuse_check_done)
    else $error("not rearmed");
  c_mode_on: cover property ($rose(fuse_check_active));
  c_path_on: cover property ($rose(fuse_check_current));
  c_done: cover property ($rose(fuse_check_done));
endmodule // jfcc_fuse_check_asserts

// file: bench/jfcc_fuse_check_bench.sv
`timescale 1ns/10ps
module jfcc_fuse_check_bench;
  import jfcc_pkg::*;
  logic mclk    = 1'h0;
  logic arst_n  = 1'h0;
  logic fuse_ok = 1'h1;
  logic exp_int = 1'h0;
  logic tms_pin, tdi_pin, cur, act, dn, intact;
  int   fail_count = 0;
  int   checked    = 0;
  always #20 mclk = ~mclk;
  jfcc_probe jfcc_probe_inst (.mclk(mclk), .fuse_ok(fuse_ok), .fuse_path(cur),
    .tms_pin(tms_pin), .tdi_pin(tdi_pin));
  jfcc_fuse_check jfcc_fuse_check_inst (.mclk(mclk), .arst_n(arst_n), .tms_pin(tms_pin),
    .test_data_in_test_clock_pin(tdi_pin), .fuse_check_current(cur),
    .fuse_check_active(act), .fuse_check_done(dn), .fuse_intact(intact));
  task chk(input logic [3:0] seen, input logic [3:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One link period per pin change, then compare path, mode, done, fuse flag
  task step(input logic v, input logic [2:0] ex);
    jfcc_probe_inst.drive(v);
    repeat (8) @(negedge mclk);
    if (ex[2]) exp_int = fuse_ok;
    chk({cur, act, dn, intact}, {ex, exp_int});
  endtask
  task por(input logic v);
    @(negedge mclk);
    arst_n  = 1'h0;
    exp_int = 1'h0;
    jfcc_probe_inst.drive(v);
    repeat (4) @(negedge mclk);
    arst_n = 1'h1;
  endtask
  task scn_low_at_por;
    por(1'h0);
    step(1'h0, 3'h6);
    step(1'h1, 3'h2);
    step(1'h0, 3'h6);
    step(1'h1, 3'h1);
    step(1'h0, 3'h1);
    step(1'h1, 3'h1);
  endtask
  task scn_rearm_blown;
    fuse_ok = 1'h0;
    por(1'h1);
    step(1'h1, 3'h0);
    step(1'h0, 3'h6);
    step(1'h1, 3'h2);
    step(1'h0, 3'h6);
    step(1'h1, 3'h1);
  endtask
  task conclude;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    scn_low_at_por();
    scn_rearm_blown();
    conclude();
  end
endmodule // jfcc_fuse_check_bench
bind jfcc_fuse_check jfcc_fuse_check_asserts jfcc_fuse_check_asserts_inst (.mclk(mclk),
  .arst_n(arst_n), .tms_pin(tms_pin), .fuse_check_current(fuse_check_current),
  .fuse_check_active(fuse_check_active), .fuse_check_done(fuse_check_done));
